// [logic/btbu_comparator.sv]
// btbu_comparator.sv: one breakpoint comparator with pass counter
`include "btbu_defines.svh"
`default_nettype none
module btbu_comparator (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_valid,
  input wire btbu_pkg::btbu_cycle_t cyc,
  input wire btbu_pkg::btbu_bp_cfg_t cfg,
  input wire logic cfg_load,
  output logic fire
);
  import btbu_pkg::*;

  logic [15:0] remaining;
  logic addr_ok;
  logic data_ok;
  logic dir_ok;
  logic sp_ok;
  logic ext_ok;
  logic hit;
  logic [EXT_W-1:0] ext_care;
  logic [EXT_W-1:0] ext_lvl;

  assign ext_care = cfg.mode[`BTBU_MODE_EXT_CARE +: EXT_W];
  assign ext_lvl = cfg.mode[`BTBU_MODE_EXT_LVL +: EXT_W];
  // cleared care bits make a field don't-care
  assign addr_ok = ((cyc.addr ^ cfg.addr) & cfg.addr_care) == '0; // see [RL10] see [RL11]
  assign data_ok = ((cyc.data ^ cfg.data) & cfg.data_care) == '0; // see [RL10] see [RL11]
  assign dir_ok = !cfg.mode[`BTBU_MODE_DIR_CARE] || (cyc.write == cfg.mode[`BTBU_MODE_DIR_WRITE]); // see [RL9]
  assign sp_ok = !cfg.mode[`BTBU_MODE_SP_CARE] || (cyc.io == cfg.mode[`BTBU_MODE_SP_IO]); // see [RL14]
  assign ext_ok = ((cyc.ext ^ ext_lvl) & ext_care) == '0; // see [RL12]
  assign hit = cyc_valid && cfg.mode[`BTBU_MODE_EN] && addr_ok && data_ok && dir_ok && sp_ok && ext_ok; // see [RL16]

  // pass counter: fire on the configured match count
  always_ff @(posedge clk) begin
    if (rst) begin
      remaining <= 16'h0001;
      fire <= 1'b0;
    end else if (cfg_load) begin
      remaining <= (cfg.count == 16'h0000) ? 16'h0001 : cfg.count;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (hit) begin
        if (remaining == 16'h0001) begin
          fire <= 1'b1; // see [RL8]
          remaining <= (cfg.count == 16'h0000) ? 16'h0001 : cfg.count;
        end else begin
          remaining <= remaining - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/btbu_defines.svh]
// btbu_defines.svh: offsets, field positions, reset values and timing counts
`ifndef BTBU_DEFINES_SVH
`define BTBU_DEFINES_SVH

`define BTBU_CLK_NS 8
`define BTBU_UNIT_100NS_NS 100
`define BTBU_UNIT_1US_NS 1000
`define BTBU_TICK_100NS ((`BTBU_UNIT_100NS_NS + `BTBU_CLK_NS - 1) / `BTBU_CLK_NS)
`define BTBU_TICK_1US ((`BTBU_UNIT_1US_NS + `BTBU_CLK_NS - 1) / `BTBU_CLK_NS)

`define BTBU_REG_CTRL 8'h00
`define BTBU_REG_STATUS 8'h04
`define BTBU_REG_IRQ_STAT 8'h08
`define BTBU_REG_IRQ_MASK 8'h0C
`define BTBU_REG_TIMER 8'h10
`define BTBU_REG_TR_INDEX 8'h14
`define BTBU_REG_TR_ADDR 8'h18
`define BTBU_REG_TR_DATA 8'h1C
`define BTBU_REG_TR_CTL 8'h20
`define BTBU_REG_BP_BASE 8'h40
`define BTBU_BP_STRIDE 8'h20
`define BTBU_BP_ADDR 8'h00
`define BTBU_BP_ADDR_CARE 8'h04
`define BTBU_BP_DATA 8'h08
`define BTBU_BP_DATA_CARE 8'h0C
`define BTBU_BP_COUNT 8'h10
`define BTBU_BP_MODE 8'h14

`define BTBU_CTRL_TRACE_EN 0
`define BTBU_CTRL_UNIT_LO 1
`define BTBU_CTRL_REARM 3
`define BTBU_CTRL_TIMER_CLR 4

`define BTBU_MODE_EN 0
`define BTBU_MODE_DIR_CARE 1
`define BTBU_MODE_DIR_WRITE 2
`define BTBU_MODE_SP_CARE 3
`define BTBU_MODE_SP_IO 4
`define BTBU_MODE_HALT 5
`define BTBU_MODE_STOP_TRACE 6
`define BTBU_MODE_EXT_LVL 8
`define BTBU_MODE_EXT_CARE 12

`define BTBU_IRQ_BP 0
`define BTBU_IRQ_FROZEN 4
`define BTBU_IRQ_TIMER_DONE 5

`define BTBU_CTRL_RESET 32'h0000_0001
`define BTBU_COUNT_RESET 16'h0001

`endif

// [logic/btbu_pkg.sv]
// btbu_pkg.sv: shared types of the bus trace and breakpoint unit
`default_nettype none
package btbu_pkg;
  parameter int ADDR_W = 24;
  parameter int DATA_W = 16;
  parameter int CTL_W = 8;
  parameter int EXT_W = 4;
  parameter int NUM_BP = 4;
  parameter int TRACE_DEPTH = 256;
  parameter int TRACE_AW = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CTL_W-1:0] ctl;
    logic write;
    logic io;
    logic [EXT_W-1:0] ext;
  } btbu_cycle_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } btbu_req_t;

  typedef enum logic [1:0] {
    BTBU_UNIT_100NS,
    BTBU_UNIT_1US,
    BTBU_UNIT_CYCLES
  } btbu_unit_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] addr_care;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] data_care;
    logic [15:0] count;
    logic [15:0] mode;
  } btbu_bp_cfg_t;
endpackage
`default_nettype wire

// [logic/btbu_top.sv]
// btbu_top.sv: bus trace and breakpoint unit top level
// Summary of operation
// [RL1] The trace buffer holds the latest bus cycles, up to 256 records.
// [RL2] Each record holds address, data, control lines and four probe lines of one cycle.
// [RL3] Tracing runs all the time whether or not anyone reads the buffer; the code stops it while bit BTBU_CTRL_TRACE_EN of ctrl is clear.
// [RL4] A user-chosen breakpoint stops tracing and freezes the buffer for readout.
// [RL5] The interval timer starts on breakpoint 1 and stops on breakpoint 2.
// [RL6] The timer counts in 100 ns units, microseconds or bus cycles.
// [RL7] Four hardware comparators watch the bus without touching user code.
// [RL8] Each breakpoint fires only after its match count has been reached.
// [RL9] Each breakpoint can be limited to read cycles or to write cycles.
// [RL10] Each breakpoint compares a programmed address and data with every cycle.
// [RL11] Address and data compares each take an exact value or don't-care.
// [RL12] Each breakpoint compares the four probe lines, each at a level or don't-care.
// [RL13] Each breakpoint selects halt of the processor or snapshot and continue.
// [RL14] Each breakpoint can qualify memory or I/O cycles, or ignore the qualifier.
// [RL15] With the buffer full, each new record overwrites the oldest one in circular order.
// [RL16] A breakpoint matches only when all its enabled qualifiers agree in one cycle.
//
// Added by the designer: the plain strobed port and the register addresses.
`include "btbu_defines.svh"
`default_nettype none
module btbu_top #(
  parameter int TICK_100NS = `BTBU_TICK_100NS,
  parameter int TICK_1US = `BTBU_TICK_1US
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic BUS_STROBE,
  input wire logic [btbu_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic [btbu_pkg::DATA_W-1:0] BUS_DATA,
  input wire logic [btbu_pkg::CTL_W-1:0] BUS_CTL,
  input wire logic BUS_WRITE,
  input wire logic BUS_IO,
  input wire logic [btbu_pkg::EXT_W-1:0] EXT_PROBE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic HALT_REQ,
  output logic SNAP_REQ,
  output logic BP_TRIGGER,
  output logic IRQ
);
  import btbu_pkg::*;

  localparam int REC_W = $bits(btbu_cycle_t);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strobe_sync;
  logic [EXT_W-1:0] ext_s1;
  logic [EXT_W-1:0] ext_s2;
  logic [EXT_W-1:0] ext_s3;
  logic [EXT_W-1:0] ext_stable;
  btbu_cycle_t bus_s1;
  btbu_cycle_t bus_s2;
  btbu_cycle_t cyc;
  logic cyc_valid;

  // strobe passes three flops; end of strobe marks a completed bus cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      strobe_sync <= 3'h0;
    end else begin
      strobe_sync <= {strobe_sync[1:0], BUS_STROBE};
    end
  end

  // probe lines count once stages two and three agree
  always_ff @(posedge CLOCK) begin
    ext_s1 <= EXT_PROBE;
    ext_s2 <= ext_s1;
    ext_s3 <= ext_s2;
    if (RST) begin
      ext_stable <= '0;
    end else if (ext_s2 == ext_s3) begin
      ext_stable <= ext_s3;
    end
  end

  // bus lines are held stable around the strobe; sample twice and latch on strobe edge
  always_ff @(posedge CLOCK) begin
    bus_s1 <= '{addr: BUS_ADDR, data: BUS_DATA, ctl: BUS_CTL, write: BUS_WRITE, io: BUS_IO, ext: '0};
    bus_s2 <= bus_s1;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cyc_valid <= 1'b0;
      cyc <= '0;
    end else begin
      cyc_valid <= strobe_sync[1] && strobe_sync[2];
      if (strobe_sync[1] && !strobe_sync[2]) begin
        cyc <= bus_s2;
        cyc.ext <= ext_stable; // see [RL2]
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [5:0] irq_stat;
  logic [5:0] irq_mask;
  logic [5:0] irq_event;
  logic [TRACE_AW-1:0] rd_index;
  btbu_bp_cfg_t bp_cfg [NUM_BP];
  logic [NUM_BP-1:0] bp_load;
  logic [NUM_BP-1:0] bp_fire;
  logic bp_region;
  logic [1:0] bp_sel;
  logic [4:0] bp_off;
  logic cyc_commit;

  assign bp_region = REG_ADDR >= `BTBU_REG_BP_BASE;
  assign bp_sel = 2'((REG_ADDR - `BTBU_REG_BP_BASE) >> 5);
  assign bp_off = 5'(REG_ADDR - `BTBU_REG_BP_BASE);
  assign cyc_commit = cyc_valid && !strobe_sync[1];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl <= `BTBU_CTRL_RESET;
      irq_mask <= '0;
      rd_index <= '0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `BTBU_REG_CTRL: ctrl <= REG_WDATA;
        `BTBU_REG_IRQ_MASK: irq_mask <= REG_WDATA[5:0];
        `BTBU_REG_TR_INDEX: rd_index <= REG_WDATA[TRACE_AW-1:0];
        default: ctrl <= ctrl;
      endcase
    end else begin
      ctrl[`BTBU_CTRL_REARM] <= 1'b0;
      ctrl[`BTBU_CTRL_TIMER_CLR] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // breakpoint comparators
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          bp_cfg[gi] <= '{addr: '0, addr_care: '0, data: '0, data_care: '0,
                          count: `BTBU_COUNT_RESET, mode: '0};
          bp_load[gi] <= 1'b0;
        end else begin
          bp_load[gi] <= 1'b0;
          if (REG_WR && bp_region && bp_sel == 2'(gi)) begin
            bp_load[gi] <= 1'b1;
            case (bp_off)
              5'(`BTBU_BP_ADDR): bp_cfg[gi].addr <= REG_WDATA[ADDR_W-1:0];
              5'(`BTBU_BP_ADDR_CARE): bp_cfg[gi].addr_care <= REG_WDATA[ADDR_W-1:0];
              5'(`BTBU_BP_DATA): bp_cfg[gi].data <= REG_WDATA[DATA_W-1:0];
              5'(`BTBU_BP_DATA_CARE): bp_cfg[gi].data_care <= REG_WDATA[DATA_W-1:0];
              5'(`BTBU_BP_COUNT): bp_cfg[gi].count <= REG_WDATA[15:0];
              5'(`BTBU_BP_MODE): bp_cfg[gi].mode <= REG_WDATA[15:0];
              default: bp_load[gi] <= 1'b0;
            endcase
          end
        end
      end

      btbu_comparator u_cmp ( // see [RL7]
        .clk(CLOCK),
        .rst(RST),
        .cyc_valid(cyc_commit),
        .cyc(cyc),
        .cfg(bp_cfg[gi]),
        .cfg_load(bp_load[gi]),
        .fire(bp_fire[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // breakpoint actions
  // ----------------------------------------------------------------
  logic any_halt;
  logic any_snap;
  logic any_stop;

  always_comb begin
    any_halt = 1'b0;
    any_snap = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < NUM_BP; i++) begin
      if (bp_fire[i]) begin
        if (bp_cfg[i].mode[`BTBU_MODE_HALT]) begin
          any_halt = 1'b1; // see [RL13]
        end else begin
          any_snap = 1'b1; // see [RL13]
        end
        if (bp_cfg[i].mode[`BTBU_MODE_STOP_TRACE]) begin
          any_stop = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      HALT_REQ <= 1'b0;
      SNAP_REQ <= 1'b0;
      BP_TRIGGER <= 1'b0;
    end else begin
      SNAP_REQ <= any_snap;
      BP_TRIGGER <= |bp_fire;
      if (any_halt) begin
        HALT_REQ <= 1'b1;
      end else if (ctrl[`BTBU_CTRL_REARM]) begin
        HALT_REQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // trace buffer
  // ----------------------------------------------------------------
  logic [TRACE_AW-1:0] wr_ptr;
  logic [TRACE_AW:0] fill;
  logic frozen;
  logic [REC_W-1:0] rd_rec;
  btbu_cycle_t rd_cyc;
  logic trace_wr;

  assign trace_wr = cyc_commit && !frozen && ctrl[`BTBU_CTRL_TRACE_EN]; // see [RL3]
  assign rd_cyc = btbu_cycle_t'(rd_rec);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_ptr <= '0;
      fill <= '0;
      frozen <= 1'b0;
    end else begin
      if (trace_wr) begin
        wr_ptr <= wr_ptr + 1'b1; // see [RL15]
        if (fill != (TRACE_AW+1)'(TRACE_DEPTH)) begin
          fill <= fill + 1'b1; // see [RL1]
        end
      end
      if (any_stop) begin
        frozen <= 1'b1; // see [RL4]
      end else if (ctrl[`BTBU_CTRL_REARM]) begin
        frozen <= 1'b0;
        fill <= '0;
      end
    end
  end

  // index 0 reads the oldest stored record
  btbu_trace_mem #(.WIDTH(REC_W), .DEPTH(TRACE_DEPTH), .AW(TRACE_AW)) u_mem (
    .clk(CLOCK),
    .wr_en(trace_wr),
    .wr_addr(wr_ptr),
    .wr_data(cyc),
    .rd_addr(TRACE_AW'(wr_ptr - TRACE_AW'(fill) + rd_index)),
    .rd_data(rd_rec)
  );

  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  logic timing;
  logic [31:0] timer;
  logic [15:0] prescale;
  logic tick;
  btbu_unit_t unit;

  assign unit = btbu_unit_t'(ctrl[`BTBU_CTRL_UNIT_LO +: 2]);

  always_comb begin
    case (unit)
      BTBU_UNIT_100NS: tick = prescale == 16'(TICK_100NS - 1); // see [RL6]
      BTBU_UNIT_1US: tick = prescale == 16'(TICK_1US - 1); // see [RL6]
      BTBU_UNIT_CYCLES: tick = cyc_commit; // see [RL6]
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST || !timing || tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      timing <= 1'b0;
      timer <= '0;
    end else begin
      if (bp_fire[1]) begin
        timing <= 1'b0; // see [RL5]
      end else if (bp_fire[0]) begin
        timing <= 1'b1; // see [RL5]
        timer <= '0;
      end else if (timing && tick) begin
        timer <= timer + 32'h0000_0001;
      end
      if (ctrl[`BTBU_CTRL_TIMER_CLR]) begin
        timer <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts and read data
  // ----------------------------------------------------------------
  assign irq_event = {timing && bp_fire[1], any_stop && !frozen, bp_fire};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_stat <= '0;
      IRQ <= 1'b0;
    end else begin
      // a new event wins over a write-one clear
      if (REG_WR && REG_ADDR == `BTBU_REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~REG_WDATA[5:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      if (bp_region) begin
        case (bp_off)
          5'(`BTBU_BP_ADDR): REG_RDATA <= 32'(bp_cfg[bp_sel].addr);
          5'(`BTBU_BP_ADDR_CARE): REG_RDATA <= 32'(bp_cfg[bp_sel].addr_care);
          5'(`BTBU_BP_DATA): REG_RDATA <= 32'(bp_cfg[bp_sel].data);
          5'(`BTBU_BP_DATA_CARE): REG_RDATA <= 32'(bp_cfg[bp_sel].data_care);
          5'(`BTBU_BP_COUNT): REG_RDATA <= 32'(bp_cfg[bp_sel].count);
          5'(`BTBU_BP_MODE): REG_RDATA <= 32'(bp_cfg[bp_sel].mode);
          default: REG_RDATA <= '0;
        endcase
      end else begin
        case (REG_ADDR)
          `BTBU_REG_CTRL: REG_RDATA <= ctrl;
          `BTBU_REG_STATUS: REG_RDATA <= {20'h0, fill, HALT_REQ, timing, frozen};
          `BTBU_REG_IRQ_STAT: REG_RDATA <= 32'(irq_stat);
          `BTBU_REG_IRQ_MASK: REG_RDATA <= 32'(irq_mask);
          `BTBU_REG_TIMER: REG_RDATA <= timer;
          `BTBU_REG_TR_INDEX: REG_RDATA <= 32'(rd_index);
          `BTBU_REG_TR_ADDR: REG_RDATA <= 32'(rd_cyc.addr);
          `BTBU_REG_TR_DATA: REG_RDATA <= 32'(rd_cyc.data);
          `BTBU_REG_TR_CTL: REG_RDATA <= {18'h0, rd_cyc.ext, rd_cyc.io, rd_cyc.write, rd_cyc.ctl};
          default: REG_RDATA <= '0;
        endcase
      end
    end else begin
      REG_RDATA <= '0;
    end
  end
endmodule
`default_nettype wire

// [logic/btbu_trace_mem.sv]
// btbu_trace_mem.sv: trace record memory with registered read port
`default_nettype none
module btbu_trace_mem #(
  parameter int WIDTH = 58,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [tb/btbu_bus_model.sv]
// btbu_bus_model.sv: emulated processor bus cycles
`default_nettype none
module btbu_bus_model (
  input wire logic clk,
  output var logic strobe,
  output var btbu_pkg::btbu_cycle_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import btbu_pkg::*;
  initial begin
    strobe = 1'h0;
    pins = '0;
  end
  // ----
  // one cycle: setup, strobe high 4, hold 5, released lines inverted
  // ----
  task automatic cycle(input btbu_cycle_t c);
    @(posedge clk);
    pins <= c;
    repeat (2) @(posedge clk);
    strobe <= 1'h1;
    repeat (4) @(posedge clk);
    strobe <= 1'h0;
    repeat (5) @(posedge clk);
    pins <= ~c;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/btbu_top_asserts.sv]
// btbu_top_asserts.sv: port-level assertions for btbu_top
`include "btbu_defines.svh"
`default_nettype none
module btbu_top_asserts #(
  parameter int TICK_100NS = `BTBU_TICK_100NS,
  parameter int TICK_1US = `BTBU_TICK_1US
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic BUS_STROBE,
  input wire logic [btbu_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic [btbu_pkg::DATA_W-1:0] BUS_DATA,
  input wire logic [btbu_pkg::CTL_W-1:0] BUS_CTL,
  input wire logic BUS_WRITE,
  input wire logic BUS_IO,
  input wire logic [btbu_pkg::EXT_W-1:0] EXT_PROBE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic HALT_REQ,
  input wire logic SNAP_REQ,
  input wire logic BP_TRIGGER,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  import btbu_pkg::*;
  logic [5:0] since_fall;
  logic rearm;
  // ----
  // cycles since the last bus strobe fall
  // ----
  always_ff @(posedge CLOCK) begin
    if (RST) since_fall <= 6'h3F;
    else if ($fell(BUS_STROBE)) since_fall <= 6'h00;
    else if (since_fall != 6'h3F) since_fall <= since_fall + 6'h01;
  end
  assign rearm = REG_WR && REG_ADDR == `BTBU_REG_CTRL && REG_WDATA[`BTBU_CTRL_REARM];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_pulse; BP_TRIGGER ##1 !BP_TRIGGER; endsequence
  sequence s_recent_cycle; since_fall inside {[6'h02:6'h0E]}; endsequence
  property p_bp_pulse; BP_TRIGGER |-> s_pulse; endproperty
  property p_fire_cause; BP_TRIGGER |-> s_recent_cycle; endproperty
  property p_snap; SNAP_REQ |-> BP_TRIGGER; endproperty
  property p_halt_rise; $rose(HALT_REQ) |-> BP_TRIGGER; endproperty
  property p_halt_hold; HALT_REQ && !rearm && !$past(rearm) |=> HALT_REQ; endproperty
  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == 32'h0; endproperty
  property p_irq_fall; $fell(IRQ) |-> $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3); endproperty
  property p_irq_rise;
    $rose(IRQ) |-> BP_TRIGGER || $past(BP_TRIGGER) || $past(BP_TRIGGER, 2) || $past(REG_WR, 2) || $past(REG_WR, 3);
  endproperty
  a_bp_pulse: assert property (p_bp_pulse) else $error("trigger pulse too long");
  a_fire_cause: assert property (p_fire_cause) else $error("trigger without bus cycle");
  a_snap: assert property (p_snap) else $error("snapshot without trigger");
  a_halt_rise: assert property (p_halt_rise) else $error("halt without trigger");
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped without rearm");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
endmodule
bind btbu_top btbu_top_asserts #(.TICK_100NS(TICK_100NS), .TICK_1US(TICK_1US)) u_chk (
  .CLOCK(CLOCK), .RST(RST), .BUS_STROBE(BUS_STROBE), .BUS_ADDR(BUS_ADDR), .BUS_DATA(BUS_DATA),
  .BUS_CTL(BUS_CTL), .BUS_WRITE(BUS_WRITE), .BUS_IO(BUS_IO), .EXT_PROBE(EXT_PROBE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .HALT_REQ(HALT_REQ),
  .SNAP_REQ(SNAP_REQ), .BP_TRIGGER(BP_TRIGGER), .IRQ(IRQ));
`default_nettype wire

// [tb/bus_trace_breakpoint_unit_tb.sv]
// bus_trace_breakpoint_unit_tb.sv: self-checking bench for btbu_top
`include "btbu_defines.svh"
`default_nettype none
module bus_trace_breakpoint_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import btbu_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic strobe;
  btbu_cycle_t pins;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic halt_req, snap_req, bp_trigger, irq;
  int n_fail = 0;
  int comparisons = 0;
  int n_trig = 0;
  int n_snap = 0;
  btbu_top uut (.CLOCK(clock), .RST(rst), .BUS_STROBE(strobe), .BUS_ADDR(pins.addr), .BUS_DATA(pins.data),
    .BUS_CTL(pins.ctl), .BUS_WRITE(pins.write), .BUS_IO(pins.io), .EXT_PROBE(pins.ext), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .HALT_REQ(halt_req),
    .SNAP_REQ(snap_req), .BP_TRIGGER(bp_trigger), .IRQ(irq));
  btbu_bus_model bus (.clk(clock), .strobe(strobe), .pins(pins));
  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (bp_trigger === 1'h1) n_trig++;
    if (snap_req === 1'h1) n_snap++;
  end
  // ----
  // shared tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(posedge clock);
    cmp(nm, e, reg_rdata);
  endtask
  function automatic btbu_cycle_t mk(input logic [23:0] a, input logic w, io, input logic [3:0] x);
    mk = '{a, a[15:0] ^ 16'hA5A5, a[7:0] ^ 8'h5A, w, io, x};
  endfunction
  function automatic logic [7:0] bpa(input int n, input logic [7:0] off);
    bpa = `BTBU_REG_BP_BASE + 8'(n) * `BTBU_BP_STRIDE + off;
  endfunction
  task automatic bpset(input int n, input logic [23:0] a, ac, input logic [15:0] d, dc, cnt, m);
    wr(bpa(n, `BTBU_BP_ADDR), {8'h0, a});
    wr(bpa(n, `BTBU_BP_ADDR_CARE), {8'h0, ac});
    wr(bpa(n, `BTBU_BP_DATA), {16'h0, d});
    wr(bpa(n, `BTBU_BP_DATA_CARE), {16'h0, dc});
    wr(bpa(n, `BTBU_BP_COUNT), {16'h0, cnt});
    wr(bpa(n, `BTBU_BP_MODE), {16'h0, m});
  endtask
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk(`BTBU_REG_CTRL, `BTBU_CTRL_RESET, "ctrl");
    chk(bpa(0, `BTBU_BP_COUNT), {16'h0, `BTBU_COUNT_RESET}, "count");
    chk(bpa(3, `BTBU_BP_MODE), 32'h0, "mode");
    wr(8'h3C, 32'hFFFF_FFFF);
    chk(8'h3C, 32'h0, "unmapped");
    chk(`BTBU_REG_IRQ_MASK, 32'h0, "mask");
  endtask
  task automatic t_ring;
    int idx[3] = '{0, 1, 255};
    btbu_cycle_t c;
    int j;
    for (int i = 0; i < 258; i++) bus.cycle(mk(24'(i), i[0], i[1], i[5:2]));
    chk(`BTBU_REG_STATUS, 32'h0000_0800, "fill");
    for (int k = 0; k < 3; k++) begin
      // index 0 holds cycle 2 once two records were overwritten
      j = idx[k] + 2;
      c = mk(24'(j), j[0], j[1], j[5:2]);
      wr(`BTBU_REG_TR_INDEX, 32'(idx[k]));
      chk(`BTBU_REG_TR_ADDR, {8'h0, c.addr}, "tr_addr");
      chk(`BTBU_REG_TR_DATA, {16'h0, c.data}, "tr_data");
      chk(`BTBU_REG_TR_CTL, {18'h0, c.ext, c.io, c.write, c.ctl}, "tr_ctl");
    end
  endtask
  task automatic t_count;
    n_trig = 0;
    n_snap = 0;
    bpset(0, 24'h001234, 24'hFFFFFF, 16'h0, 16'h0, 16'h0003, 16'h0007);
    bus.cycle(mk(24'h001234, 1'h1, 1'h0, 4'h0));
    bus.cycle(mk(24'h001234, 1'h0, 1'h0, 4'h0));
    bus.cycle(mk(24'h001235, 1'h1, 1'h0, 4'h0));
    bus.cycle(mk(24'h001234, 1'h1, 1'h0, 4'h0));
    cmp("trig_early", 32'h0, n_trig);
    bus.cycle(mk(24'h001234, 1'h1, 1'h0, 4'h0));
    cmp("trig", 32'h1, n_trig);
    cmp("snap", 32'h1, n_snap);
    cmp("halt", 32'h0, {31'h0, halt_req});
    chk(`BTBU_REG_IRQ_STAT, 32'h1, "irq_stat");
    cmp("irq_masked", 32'h0, {31'h0, irq});
    wr(`BTBU_REG_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clock);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`BTBU_REG_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clock);
    cmp("irq_clr", 32'h0, {31'h0, irq});
    wr(`BTBU_REG_IRQ_MASK, 32'h0);
    wr(bpa(0, `BTBU_BP_MODE), 32'h0);
  endtask
  task automatic t_freeze;
    n_trig = 0;
    bpset(1, 24'h0, 24'h0, 16'h0777 ^ 16'hA5A5, 16'hFFFF, 16'h0001, 16'hCA7B);
    bus.cycle(mk(24'h000777, 1'h0, 1'h1, 4'h2));
    bus.cycle(mk(24'h000777, 1'h0, 1'h0, 4'h9));
    bus.cycle(mk(24'h000778, 1'h0, 1'h1, 4'h9));
    cmp("trig_none", 32'h0, n_trig);
    bus.cycle(mk(24'h100777, 1'h0, 1'h1, 4'h9));
    cmp("trig_all", 32'h1, n_trig);
    cmp("halt", 32'h1, {31'h0, halt_req});
    bus.cycle(mk(24'h000001, 1'h0, 1'h0, 4'h0));
    chk(`BTBU_REG_STATUS, 32'h0000_0805, "frozen");
    wr(`BTBU_REG_TR_INDEX, 32'hFF);
    chk(`BTBU_REG_TR_ADDR, 32'h0010_0777, "tr_last");
    // timer was left running by the earlier breakpoint 0 hit
    chk(`BTBU_REG_IRQ_STAT, 32'h32, "irq_stat");
    wr(`BTBU_REG_CTRL, 32'h9);
    repeat (2) @(posedge clock);
    cmp("halt_clr", 32'h0, {31'h0, halt_req});
    chk(`BTBU_REG_STATUS, 32'h0, "rearm");
    wr(`BTBU_REG_IRQ_STAT, 32'h32);
    wr(bpa(1, `BTBU_BP_MODE), 32'h0);
  endtask
  task automatic t_timer(input logic [1:0] u, input int mid, lo, hi);
    logic [31:0] v;
    wr(`BTBU_REG_CTRL, {28'h1, 1'h0, u, 1'h1});
    bpset(0, 24'h000A00, 24'hFFFFFF, 16'h0, 16'h0, 16'h0001, 16'h0001);
    bpset(1, 24'h000B00, 24'hFFFFFF, 16'h0, 16'h0, 16'h0001, 16'h0001);
    bus.cycle(mk(24'h000A00, 1'h0, 1'h0, 4'h0));
    chk(`BTBU_REG_IRQ_STAT, 32'h1, "start");
    for (int i = 0; i < mid; i++) bus.cycle(mk(24'h000C00, 1'h0, 1'h0, 4'h0));
    bus.cycle(mk(24'h000B00, 1'h0, 1'h0, 4'h0));
    @(posedge clock);
    reg_addr <= `BTBU_REG_TIMER;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(posedge clock);
    v = reg_rdata;
    cmp("timer_range", 32'h1, {31'h0, v >= 32'(lo) && v <= 32'(hi)});
    bus.cycle(mk(24'h000C00, 1'h0, 1'h0, 4'h0));
    chk(`BTBU_REG_TIMER, v, "timer_stop");
    chk(`BTBU_REG_IRQ_STAT, 32'h23, "timer_done");
    wr(`BTBU_REG_IRQ_STAT, 32'h23);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    t_reset;
    t_ring;
    t_count;
    t_freeze;
    t_timer(BTBU_UNIT_CYCLES, 3, 3, 5);
    t_timer(BTBU_UNIT_100NS, 3, 4, 7);
    t_timer(BTBU_UNIT_1US, 19, 2, 3);
    end_sim;
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
